// >>> tbpc_pkg.sv
// tbpc_pkg: register indices, field positions, reset values and counts
// assumes: pclk is the oscillator clock; byte address = 4 * register index
package tbpc_pkg;

   // ----------------------------------------
   // register indices (byte address = 4 * index)
   // ----------------------------------------
   localparam logic [7:0] IDX_GIC = 8'h0B;
   localparam logic [7:0] IDX_PIF = 8'h0C;
   localparam logic [7:0] IDX_CNT = 8'h11;
   localparam logic [7:0] IDX_CTL = 8'h12;
   localparam logic [7:0] IDX_DBUF = 8'h15;
   localparam logic [7:0] IDX_DACT = 8'h16;
   localparam logic [7:0] IDX_CHC = 8'h17;
   localparam logic [7:0] IDX_PCD = 8'h87;
   localparam logic [7:0] IDX_PIE = 8'h8C;
   localparam logic [7:0] IDX_LIM = 8'h92;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [7:0] RST_GIC = 8'h00;
   localparam logic [7:0] RST_CNT = 8'h00;
   localparam logic [6:0] RST_CTL = 7'h00;
   localparam logic [7:0] RST_DBUF = 8'h00;
   localparam logic [7:0] RST_DACT = 8'h00;
   localparam logic [5:0] RST_CHC = 6'h00;
   localparam logic [7:0] RST_PCD = 8'hFF;
   localparam logic [7:0] RST_PIE = 8'h00;
   localparam logic [7:0] RST_LIM = 8'hFF;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int CTL_POST_HI = 6;
   localparam int CTL_POST_LO = 3;
   localparam int CTL_RUN = 2;
   localparam int CTL_PSC_HI = 1;
   localparam int CTL_PSC_LO = 0;
   localparam int CHC_DLOW_HI = 5;
   localparam int CHC_DLOW_LO = 4;
   localparam int CHC_MODE_HI = 3;
   localparam int CHC_MODE_LO = 0;
   localparam int PIF_MATCH = 1;
   localparam int PCD_PWM_PIN = 2;

   // ----------------------------------------
   // modes and counts
   // ----------------------------------------
   localparam logic [3:0] MODE_PWM = 4'hC;
   localparam logic [3:0] MODE_PWM_MASK = 4'hC;
   localparam int QCLK_DIV = 4;
   localparam logic [1:0] Q_LAST = 2'(QCLK_DIV - 1);
   localparam logic [3:0] PRE_LAST_1 = 4'h0;
   localparam logic [3:0] PRE_LAST_4 = 4'h3;
   localparam logic [3:0] PRE_LAST_16 = 4'hF;

endpackage : tbpc_pkg

// >>> tbpc_divider.sv
// tbpc_divider: wrapping counter giving a one-cycle tick at its last count
// assumes: en and clr come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module tbpc_divider #(
   parameter int W = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clr,
   input wire logic en,
   input wire logic [W-1:0] last,
   output logic [W-1:0] cnt,
   output logic tick
);
   logic [W-1:0] cnt_r;

   assign tick = en && (cnt_r == last);
   assign cnt = cnt_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
      end else if (clr) begin
         cnt_r <= '0;
      end else if (en) begin
         cnt_r <= tick ? '0 : cnt_r + 1'b1;
      end
   end
endmodule : tbpc_divider
`default_nettype wire

// >>> tbpc_top.sv
// tbpc_top: period timer with prescaler/postscaler and one pwm channel
// assumes: apb master on pclk; pclk is the oscillator clock
//
// Function
// - period is (limit+1) x 4 oscillator clocks x prescale ratio
// - counter equal to limit clears on the next increment
// - output goes high at period start unless duty is zero
// - duty buffer moves to active latch only at period boundary
// - duty is 10 bits: buffer high byte, channel control bits 5:4 low
// - output clears when active duty equals counter with two extra bits
// - duty above period never matches, output stays high
// - active duty latch is read only in every mode
// - clearing channel control forces the pwm output low
// - postscaler has no effect on the pwm period
// - postscale field bits 6:3 divides matches by field plus one
// - prescale bits 1:0: 00 by 1, 01 by 4, 1x by 16
// - run bit 2 of counter control starts and stops the counter
// - counter clocked by oscillator over four through the prescaler
// - postscaler completion sets the period match flag
// - counter or control write clears pre/postscaler, control keeps counter
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module tbpc_top
   import tbpc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [9:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic pwm_output_pin,
   output logic pwm_output_pin_oe
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [7:0] gic_r;
   logic flag_r;
   logic [7:0] cnt_r;
   logic [6:0] ctl_r;
   logic [7:0] dbuf_r;
   logic [7:0] dact_r;
   logic [1:0] dlow_r;
   logic [5:0] chc_r;
   logic [7:0] pcd_r;
   logic [7:0] pie_r;
   logic [7:0] lim_r;
   logic out_r;
   logic [31:0] prdata_r;
   logic pslverr_r;

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   wire acc = psel && penable;
   wire setup = psel && !penable;
   wire [7:0] idx = paddr[9:2];
   wire aligned = (paddr[1:0] == 2'b00);
   wire hit_gic = aligned && (idx == IDX_GIC);
   wire hit_pif = aligned && (idx == IDX_PIF);
   wire hit_cnt = aligned && (idx == IDX_CNT);
   wire hit_ctl = aligned && (idx == IDX_CTL);
   wire hit_dbuf = aligned && (idx == IDX_DBUF);
   wire hit_dact = aligned && (idx == IDX_DACT);
   wire hit_chc = aligned && (idx == IDX_CHC);
   wire hit_pcd = aligned && (idx == IDX_PCD);
   wire hit_pie = aligned && (idx == IDX_PIE);
   wire hit_lim = aligned && (idx == IDX_LIM);
   wire mapped = hit_gic | hit_pif | hit_cnt | hit_ctl | hit_dbuf | hit_dact | hit_chc | hit_pcd | hit_pie | hit_lim;
   wire wr = acc && pwrite && pstrb[0];
   wire [7:0] wd = pwdata[7:0];
   wire wr_gic = wr && hit_gic;
   wire wr_pif = wr && hit_pif;
   wire wr_cnt = wr && hit_cnt;
   wire wr_ctl = wr && hit_ctl;
   wire wr_dbuf = wr && hit_dbuf;
   wire wr_chc = wr && hit_chc;
   wire wr_pcd = wr && hit_pcd;
   wire wr_pie = wr && hit_pie;
   wire wr_lim = wr && hit_lim;

   // ----------------------------------------
   // control fields
   // ----------------------------------------
   wire [3:0] post_sel = ctl_r[CTL_POST_HI:CTL_POST_LO];
   wire run = ctl_r[CTL_RUN];
   wire [1:0] psc_sel = ctl_r[CTL_PSC_HI:CTL_PSC_LO];
   wire [1:0] duty_low = chc_r[CHC_DLOW_HI:CHC_DLOW_LO];
   wire pwm_mode = ((chc_r[CHC_MODE_HI:CHC_MODE_LO] & MODE_PWM_MASK) == MODE_PWM);
   wire [9:0] duty_nxt = {dbuf_r, duty_low};

   // ----------------------------------------
   // clock chain: q clock, prescaler, postscaler
   // ----------------------------------------
   wire [1:0] q_cnt;
   wire q_tick;
   wire [3:0] pre_cnt;
   wire pre_tick;
   wire [3:0] post_cnt;
   wire post_tick;
   wire scaler_clr = wr_cnt | wr_ctl;
   wire [3:0] pre_last = psc_sel[1] ? PRE_LAST_16 : (psc_sel[0] ? PRE_LAST_4 : PRE_LAST_1);
   wire inc = run && pre_tick;
   wire wrap = inc && (cnt_r == lim_r);
   wire [1:0] ext = (psc_sel == 2'b00) ? q_cnt : (psc_sel[1] ? pre_cnt[3:2] : pre_cnt[1:0]);
   // the duty position advances by one step at each edge where step is high
   wire step = run && ((psc_sel == 2'b00) ? 1'b1 : (psc_sel[1] ? (q_tick && pre_cnt[1:0] == 2'b11) : q_tick));
   // the output register lags one cycle, so match the position that the next cycle holds
   wire [9:0] pos_nxt = {cnt_r, ext} + 10'h001;
   wire cmp_eq = step && ({dact_r, dlow_r} == pos_nxt);

   tbpc_divider #(.W(2)) u_qclk (
      .clk(pclk),
      .rst_n(presetn),
      .clr(1'b0),
      .en(1'b1),
      .last(Q_LAST),
      .cnt(q_cnt),
      .tick(q_tick)
   );

   tbpc_divider #(.W(4)) u_pre (
      .clk(pclk),
      .rst_n(presetn),
      .clr(scaler_clr),
      .en(q_tick),
      .last(pre_last),
      .cnt(pre_cnt),
      .tick(pre_tick)
   );

   tbpc_divider #(.W(4)) u_post (
      .clk(pclk),
      .rst_n(presetn),
      .clr(scaler_clr),
      .en(wrap),
      .last(post_sel),
      .cnt(post_cnt),
      .tick(post_tick)
   );

   // ----------------------------------------
   // next values
   // ----------------------------------------
   wire [7:0] cnt_nxt = wr_cnt ? wd : (wrap ? 8'h00 : (inc ? cnt_r + 8'h01 : cnt_r));
   wire out_nxt = !pwm_mode ? 1'b0 : (wrap ? (duty_nxt != 10'h000) : ((run && cmp_eq) ? 1'b0 : out_r));
   wire flag_nxt = post_tick | (wr_pif ? wd[PIF_MATCH] : flag_r);
   wire [7:0] rd_val =
      hit_gic ? gic_r :
      hit_pif ? {6'h00, flag_r, 1'b0} :
      hit_cnt ? cnt_r :
      hit_ctl ? {1'b0, ctl_r} :
      hit_dbuf ? dbuf_r :
      hit_dact ? dact_r :
      hit_chc ? {2'b00, chc_r} :
      hit_pcd ? pcd_r :
      hit_pie ? pie_r :
      hit_lim ? lim_r : 8'h00;

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gic_r <= RST_GIC;
         ctl_r <= RST_CTL;
         dbuf_r <= RST_DBUF;
         chc_r <= RST_CHC;
         pcd_r <= RST_PCD;
         pie_r <= RST_PIE;
         lim_r <= RST_LIM;
      end else begin
         if (wr_gic) gic_r <= wd;
         if (wr_ctl) ctl_r <= wd[6:0];
         if (wr_dbuf) dbuf_r <= wd;
         if (wr_chc) chc_r <= wd[5:0];
         if (wr_pcd) pcd_r <= wd;
         if (wr_pie) pie_r <= wd;
         if (wr_lim) lim_r <= wd;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= RST_CNT;
         flag_r <= 1'b0;
         out_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         flag_r <= flag_nxt;
         out_r <= out_nxt;
      end
   end

   // active latch has no write path
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dact_r <= RST_DACT;
         dlow_r <= 2'b00;
      end else if (wrap) begin
         dact_r <= dbuf_r;
         dlow_r <= duty_low;
      end
   end

   // read data captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else if (setup) begin
         prdata_r <= {24'h00_0000, rd_val};
         pslverr_r <= !mapped;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign prdata = prdata_r;
   assign pready = 1'b1;
   assign pslverr = pslverr_r;
   assign pwm_output_pin = out_r;
   assign pwm_output_pin_oe = !pcd_r[PCD_PWM_PIN];

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   wrap_clears_count_a: assert property (wrap && !wr_cnt |=> cnt_r == 8'h00)
      else $error("counter not cleared after period match");
   period_start_high_a: assert property (wrap && pwm_mode && duty_nxt != 10'h000 |=> pwm_output_pin)
      else $error("output not set at period start");
   zero_duty_low_a: assert property (wrap && pwm_mode && duty_nxt == 10'h000 |=> !pwm_output_pin)
      else $error("output set with zero duty");
   duty_hold_a: assert property (!wrap |=> $stable({dact_r, dlow_r}))
      else $error("active duty changed outside period boundary");
   duty_load_a: assert property (wrap |=> {dact_r, dlow_r} == $past(duty_nxt))
      else $error("active duty not loaded from buffer");
   compare_clear_a: assert property (pwm_mode && run && !wrap && cmp_eq |=> !pwm_output_pin)
      else $error("output not cleared on duty match");
   mode_off_low_a: assert property (!pwm_mode |=> !pwm_output_pin)
      else $error("output high with channel control cleared");
   stop_hold_a: assert property (!run && !wr_cnt && pwm_mode |=> $stable(cnt_r) && $stable(pwm_output_pin))
      else $error("counter or output moved while stopped");
   post_flag_a: assert property (post_tick |=> flag_r)
      else $error("match flag not set by postscaler");
   scaler_clear_a: assert property (wr_ctl |=> pre_cnt == 4'h0 && post_cnt == 4'h0 && cnt_r == $past(cnt_nxt))
      else $error("scalers not cleared on control write");
   inc_rate_a: assert property (inc |-> q_tick && q_cnt == Q_LAST)
      else $error("counter advanced off the instruction clock");
   unmapped_err_a: assert property (setup && !mapped ##1 acc |-> pslverr)
      else $error("unmapped access without error");

   wrap_c: cover property (wrap && pwm_mode);
   clear_c: cover property (pwm_mode && run && cmp_eq && out_r);
   flag_c: cover property (post_tick && post_sel != 4'h0);
   zero_duty_c: cover property (wrap && pwm_mode && duty_nxt == 10'h000);

endmodule : tbpc_top
`default_nettype wire

// >>> tbpc_load.sv
// tbpc_load: external load on the pwm pin, measures high time and period
// assumes: pin sampled on pclk, only while its driver is enabled
`timescale 1ns/1ps
`default_nettype none
module tbpc_load (
   input wire logic clk,
   input wire logic pin,
   input wire logic oe,
   output logic meas_v,
   output logic [15:0] hi_n,
   output logic [15:0] per_n
);
   logic [15:0] hi_r = 0;
   logic [15:0] per_r = 0;
   logic last_r = 0;
   logic lvl;
   assign lvl = pin & oe;
   always_ff @(posedge clk) begin
      last_r <= lvl;
      meas_v <= 0;
      if (lvl && !last_r) begin
         meas_v <= 1;
         hi_n <= hi_r;
         per_n <= per_r;
         hi_r <= 1;
         per_r <= 1;
      end else begin
         hi_r <= hi_r + 16'(lvl);
         per_r <= per_r + 1;
      end
   end
endmodule : tbpc_load
`default_nettype wire

// >>> tb_top.sv
// tb_top: apb driven bench for the pwm timer channel with a load model
// assumes: tbpc_pkg, tbpc_top and tbpc_load compiled before it
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import tbpc_pkg::*;
;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [9:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, seed = 32'h19A5D02C;
   logic [3:0] pstrb = 0;
   logic pready, pslverr, pin, oe, meas_v;
   logic [15:0] hi_n, per_n;
   logic [8:0] e;
   logic [8:0] rdq[$];
   logic [31:0] pwq[$];
   int err_count = 0, num_checks = 0, cyc_n = 0;
   logic [7:0] ri [10] = '{IDX_GIC, IDX_PIF, IDX_CNT, IDX_CTL, IDX_DBUF, IDX_DACT, IDX_CHC, IDX_PCD, IDX_PIE, IDX_LIM};
   logic [7:0] rv [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'hFF};

   initial forever #25 pclk = ~pclk;

   tbpc_top tbpc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pwm_output_pin(pin), .pwm_output_pin_oe(oe));
   tbpc_load tbpc_load_i (.clk(pclk), .pin(pin), .oe(oe), .meas_v(meas_v), .hi_n(hi_n), .per_n(per_n));

   // ----
   // helpers
   // ----
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic test_done();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done

   // one transfer; reads note {error, data} for the monitor
   task automatic apb(logic wr, logic [7:0] i, logic [7:0] d, logic [8:0] exp = 0, logic [1:0] lo = 0);
      logic [31:0] r;
      r = rnd();
      if (!wr) rdq.push_back(exp);
      psel <= 1;
      penable <= 0;
      pwrite <= wr;
      paddr <= {i, lo};
      pwdata <= {r[31:8], d};
      pstrb <= {r[3:1], 1'b1};
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
   endtask : apb

   task automatic idle(int n);
      psel <= 0;
      penable <= 0;
      repeat (n) @(posedge pclk);
   endtask : idle

   // pin must hold one level for many cycles
   task automatic flat(logic lv, string nm);
      int n;
      n = 0;
      idle(40);
      repeat (64) @(negedge pclk) n += int'(pin === lv);
      chk(nm, 64, n);
      @(posedge pclk);
   endtask : flat

   // ----
   // monitors
   // ----
   always @(posedge pclk) begin
      cyc_n++;
      if (psel && penable && pready === 1'b1 && !pwrite && rdq.size() > 0) begin
         e = rdq.pop_front();
         chk("read", {e[8], 23'h0, e[7:0]}, {pslverr, prdata[30:0]});
      end
      if (meas_v === 1'b1 && pwq.size() > 0) chk("pwm hi/per", pwq.pop_front(), {hi_n, per_n});
      if (cyc_n == 60000) begin
         err_count++;
         test_done();
      end
   end

   initial begin
      logic [7:0] dv;
      int r;
      repeat (16) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      foreach (ri[k]) apb(0, ri[k], 0, {1'b0, rv[k]});
      apb(0, 8'h00, 0, 9'h100);
      apb(0, IDX_LIM, 0, 9'h100, 2'b10);
      apb(1, IDX_DACT, 8'h55);
      apb(0, IDX_DACT, 0, 9'h000);
      dv = 8'(rnd());
      apb(1, IDX_DBUF, dv);
      apb(0, IDX_DBUF, 0, {1'b0, dv});
      apb(1, IDX_CNT, 8'h02);
      idle(20);
      apb(0, IDX_CNT, 0, 9'h002);
      apb(1, IDX_LIM, 8'h03);
      apb(1, IDX_DBUF, 8'h01);
      apb(1, IDX_CHC, 8'h20);
      apb(1, IDX_PCD, 8'hFB);
      idle(1);
      chk("oe", 1, oe);
      for (int ps = 0; ps < 4; ps++) begin
         apb(1, IDX_CTL, 8'(ps * 40 + 4 + ps));
         apb(1, IDX_CHC, 8'h2C);
         idle(1);
         r = (ps == 0) ? 1 : (ps == 1) ? 4 : 16;
         repeat (2) @(posedge pclk iff meas_v === 1'b1);
         @(negedge pclk);
         pwq.push_back({16'(6 * r), 16'(16 * r)});
         @(posedge pclk iff meas_v === 1'b1);
      end
      apb(0, IDX_DACT, 0, 9'h001);
      apb(1, IDX_CTL, 8'h04);
      apb(1, IDX_DBUF, 8'h10);
      flat(1, "pin above period");
      apb(1, IDX_CTL, 8'h00);
      flat(1, "pin held");
      apb(1, IDX_CTL, 8'h04);
      apb(1, IDX_DBUF, 8'h00);
      apb(1, IDX_CHC, 8'h0C);
      flat(0, "pin zero duty");
      apb(1, IDX_DBUF, 8'h10);
      flat(1, "pin high again");
      apb(1, IDX_CHC, 8'h00);
      flat(0, "pin cleared");
      apb(1, IDX_CTL, 8'h08);
      apb(1, IDX_PIF, 8'h00);
      apb(1, IDX_CNT, 8'h00);
      apb(1, IDX_CTL, 8'h0C);
      idle(18);
      apb(0, IDX_PIF, 0, 9'h000);
      idle(16);
      apb(0, IDX_PIF, 0, 9'h002);
      idle(4);
      test_done();
   end
endmodule : tb_top
`default_nettype wire
